/* sfr_read.sv */
// Device-side array read path of a serial flash, single and dual output
//
// Operation
// - Opcode is eight bits, MSB first
// - 24-bit address follows MSB first, loads counter
// - Fast read skips one dummy byte, slow none
// - Single output: eight clocks per byte, streaming
// - Address counter advances one per byte
// - Chip select release floats SO one clock after the filtered select drops
// - Counter wraps from last location to zero
// - Dual read turns SI into an output
// - Dual output: four clocks per byte, no gaps
// - Dual pairs: high bit on SO, low on SI
// - Chip select release floats SO and SI
// - Format digits count command, address, data lines
`timescale 1ns/1ps
module sfr_read (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   // Serial bus pins
   input  wire logic        cs_n_i,
   input  wire logic        sclk_i,
   input  wire logic        si_i,
   output logic             si_o,
   output logic             si_oe_o,
   output logic             so_o,
   output logic             so_oe_o,
   // Array fetch port
   output logic             mem_req_o,
   output logic [23:0]      mem_addr_o,
   input  wire logic        mem_rvalid_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             mem_rready_o
);

   // ==========================================================================
   // Pin synchroniser
   logic [2:0]        s1_ff, s2_ff, s3_ff, flt_ff, flt_d_ff;
   logic [2:0]        nxt_flt;
   sfr_pkg::sfr_pins_t pin_now, pin_old;
   logic              cs_act, sck_rise, sck_fall, si_s;

   // A change counts once stages two and three agree, filtering runt glitches
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_comb begin
            nxt_flt[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : flt_ff[g];
         end
      end
   endgenerate

   // Registers of the synchroniser; stage one feeds stage two only
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s1_ff    <= sfr_pkg::PIN_IDLE;
         s2_ff    <= sfr_pkg::PIN_IDLE;
         s3_ff    <= sfr_pkg::PIN_IDLE;
         flt_ff   <= sfr_pkg::PIN_IDLE;
         flt_d_ff <= sfr_pkg::PIN_IDLE;
      end else begin
         s1_ff    <= {cs_n_i, sclk_i, si_i};
         s2_ff    <= s1_ff;
         s3_ff    <= s2_ff;
         flt_ff   <= nxt_flt;
         flt_d_ff <= flt_ff;
      end
   end

   // Edge finding works the same whether the clock idles low or high
   assign pin_now  = flt_ff;
   assign pin_old  = flt_d_ff;
   assign cs_act   = ~pin_now.cs_n;
   assign sck_rise = cs_act & pin_now.sclk & ~pin_old.sclk;
   assign sck_fall = cs_act & ~pin_now.sclk & pin_old.sclk;
   assign si_s     = pin_now.si;

   // ==========================================================================
   // Command, address and dummy phases
   sfr_pkg::sfr_state_t state_ff, nxt_state;
   logic [5:0]        bit_cnt_ff, nxt_bit_cnt;
   logic [7:0]        cmd_ff, nxt_cmd;
   logic [23:0]       addr_sh_ff, nxt_addr_sh;
   logic [23:0]       fetch_addr_ff, nxt_fetch_addr;
   logic              fetch_en_ff, nxt_fetch_en;
   logic              dual_ff, nxt_dual;
   logic              issue;
   logic [7:0]        cmd_full;
   logic [23:0]       addr_full;

   assign cmd_full  = {cmd_ff[6:0], si_s};
   assign addr_full = {addr_sh_ff[22:0], si_s};

   // Phase sequencing on sampled rising edges
   always_comb begin
      nxt_state      = state_ff;
      nxt_bit_cnt    = bit_cnt_ff;
      nxt_cmd        = cmd_ff;
      nxt_addr_sh    = addr_sh_ff;
      nxt_fetch_addr = fetch_addr_ff;
      nxt_fetch_en   = fetch_en_ff;
      nxt_dual       = dual_ff;
      if (issue) begin
         // Prefetch walks the array; wrap adds no dead clocks
         if (fetch_addr_ff == sfr_pkg::ARRAY_LAST) begin
            nxt_fetch_addr = sfr_pkg::ARRAY_FIRST;
         end else begin
            nxt_fetch_addr = fetch_addr_ff + sfr_pkg::ADDR_STEP;
         end
      end
      if (!cs_act) begin
         nxt_state    = sfr_pkg::ST_CMD;
         nxt_bit_cnt  = sfr_pkg::CNT_ZERO;
         nxt_fetch_en = 1'b0;
         nxt_dual     = 1'b0;
      end else if (sck_rise) begin
         nxt_bit_cnt = bit_cnt_ff + sfr_pkg::CNT_ONE;
         case (state_ff)
            sfr_pkg::ST_CMD: begin
               nxt_cmd = cmd_full;
               if (bit_cnt_ff == sfr_pkg::CMD_LAST) begin
                  nxt_bit_cnt = sfr_pkg::CNT_ZERO;
                  case (cmd_full)
                     sfr_pkg::OP_READ_SLOW, sfr_pkg::OP_READ_FAST: begin
                        nxt_state = sfr_pkg::ST_ADDR;
                     end
                     sfr_pkg::OP_READ_DUAL: begin
                        nxt_state = sfr_pkg::ST_ADDR;
                        nxt_dual  = 1'b1;
                     end
                     default: begin
                        nxt_state = sfr_pkg::ST_SKIP;
                     end
                  endcase
               end
            end
            sfr_pkg::ST_ADDR: begin
               nxt_addr_sh = addr_full;
               if (bit_cnt_ff == sfr_pkg::ADDR_LAST) begin
                  nxt_bit_cnt    = sfr_pkg::CNT_ZERO;
                  nxt_fetch_addr = addr_full;
                  nxt_fetch_en   = 1'b1;
                  // Slow read has no dummy byte, the others have one
                  nxt_state = (cmd_ff == sfr_pkg::OP_READ_SLOW) ?
                              sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
               end
            end
            sfr_pkg::ST_DUMMY: begin
               // Dummy bits are sampled and thrown away
               if (bit_cnt_ff == sfr_pkg::DUMMY_LAST) begin
                  nxt_bit_cnt = sfr_pkg::CNT_ZERO;
                  nxt_state   = sfr_pkg::ST_DATA;
               end
            end
            sfr_pkg::ST_DATA, sfr_pkg::ST_SKIP: begin
               nxt_bit_cnt = sfr_pkg::CNT_ZERO;
            end
            default: begin
               nxt_state = sfr_pkg::ST_SKIP;
            end
         endcase
      end
   end

   // Registers of the phase logic
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state_ff      <= sfr_pkg::ST_CMD;
         bit_cnt_ff    <= sfr_pkg::CNT_ZERO;
         cmd_ff        <= 8'h00;
         addr_sh_ff    <= 24'h000000;
         fetch_addr_ff <= sfr_pkg::ARRAY_FIRST;
         fetch_en_ff   <= 1'b0;
         dual_ff       <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         bit_cnt_ff    <= nxt_bit_cnt;
         cmd_ff        <= nxt_cmd;
         addr_sh_ff    <= nxt_addr_sh;
         fetch_addr_ff <= nxt_fetch_addr;
         fetch_en_ff   <= nxt_fetch_en;
         dual_ff       <= nxt_dual;
      end
   end

   // ==========================================================================
   // Array fetch and two-entry byte buffer
   logic [7:0]        buf_ff [2];
   logic [7:0]        nxt_buf [2];
   logic              wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
   logic [1:0]        cnt_ff, nxt_cnt;
   logic              pend_ff, nxt_pend, stale_ff, nxt_stale;
   logic              req_ff, nxt_req, rready_ff, nxt_rready;
   logic [23:0]       maddr_ff, nxt_maddr;
   logic              push, pop, take;
   logic [7:0]        head;

   // One fetch in flight at most, so an answer always finds room
   assign issue = fetch_en_ff & cs_act & ~pend_ff & (cnt_ff < sfr_pkg::BUF_DEPTH);
   assign take  = mem_rvalid_i & rready_ff & pend_ff;
   assign push  = take & ~stale_ff & cs_act;
   assign head  = (cnt_ff == sfr_pkg::BUF_EMPTY) ? 8'h00 : buf_ff[rd_ptr_ff];

   // Buffer pointers, occupancy and the fetch handshake
   always_comb begin
      nxt_buf    = buf_ff;
      nxt_wr_ptr = wr_ptr_ff;
      nxt_rd_ptr = rd_ptr_ff;
      nxt_cnt    = cnt_ff;
      nxt_req    = issue;
      nxt_maddr  = issue ? fetch_addr_ff : maddr_ff;
      nxt_pend   = issue | (pend_ff & ~take);
      // An answer owed to an ended transfer is dropped when it comes
      nxt_stale  = (stale_ff | (pend_ff & ~cs_act)) & ~take;
      if (push) begin
         nxt_buf[wr_ptr_ff] = mem_rdata_i;
         nxt_wr_ptr         = ~wr_ptr_ff;
      end
      if (pop) begin
         nxt_rd_ptr = ~rd_ptr_ff;
      end
      case ({push, pop})
         2'b10:   nxt_cnt = cnt_ff + sfr_pkg::BUF_ONE;
         2'b01:   nxt_cnt = cnt_ff - sfr_pkg::BUF_ONE;
         default: nxt_cnt = cnt_ff;
      endcase
      if (!cs_act) begin
         nxt_wr_ptr = 1'b0;
         nxt_rd_ptr = 1'b0;
         nxt_cnt    = sfr_pkg::BUF_EMPTY;
      end
      nxt_rready = (nxt_cnt < sfr_pkg::BUF_DEPTH);
   end

   // Registers of the fetch path
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         buf_ff[0] <= 8'h00;
         buf_ff[1] <= 8'h00;
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= sfr_pkg::BUF_EMPTY;
         pend_ff   <= 1'b0;
         stale_ff  <= 1'b0;
         req_ff    <= 1'b0;
         rready_ff <= 1'b1;
         maddr_ff  <= sfr_pkg::ARRAY_FIRST;
      end else begin
         buf_ff    <= nxt_buf;
         wr_ptr_ff <= nxt_wr_ptr;
         rd_ptr_ff <= nxt_rd_ptr;
         cnt_ff    <= nxt_cnt;
         pend_ff   <= nxt_pend;
         stale_ff  <= nxt_stale;
         req_ff    <= nxt_req;
         rready_ff <= nxt_rready;
         maddr_ff  <= nxt_maddr;
      end
   end

   assign mem_req_o    = req_ff;
   assign mem_addr_o   = maddr_ff;
   assign mem_rready_o = rready_ff;

   // ==========================================================================
   // Data shifter, driven on falling edges
   logic [2:0]        out_cnt_ff, nxt_out_cnt;
   logic [7:0]        sh_ff, nxt_sh;
   sfr_pkg::sfr_drive_t so_ff, si_ff, nxt_so, nxt_si;
   logic              byte_start;

   assign byte_start = (state_ff == sfr_pkg::ST_DATA) & sck_fall & (out_cnt_ff == sfr_pkg::OUT_ZERO);
   assign pop        = byte_start & (cnt_ff != sfr_pkg::BUF_EMPTY);

   // Bytes go out MSB first; an empty buffer sends zeros
   always_comb begin
      nxt_out_cnt = out_cnt_ff;
      nxt_sh      = sh_ff;
      nxt_so      = so_ff;
      nxt_si      = si_ff;
      if (!cs_act) begin
         nxt_out_cnt = sfr_pkg::OUT_ZERO;
         nxt_so.oe   = 1'b0;
         nxt_si.oe   = 1'b0;
      end else if ((state_ff == sfr_pkg::ST_DATA) && sck_fall) begin
         if (out_cnt_ff == sfr_pkg::OUT_ZERO) begin
            nxt_so = '{oe: 1'b1, d: head[7]};
            if (dual_ff) begin
               nxt_si = '{oe: 1'b1, d: head[6]};
               nxt_sh = {head[5:0], 2'b00};
            end else begin
               nxt_sh = {head[6:0], 1'b0};
            end
         end else if (dual_ff) begin
            nxt_so.d = sh_ff[7];
            nxt_si.d = sh_ff[6];
            nxt_sh   = {sh_ff[5:0], 2'b00};
         end else begin
            nxt_so.d = sh_ff[7];
            nxt_sh   = {sh_ff[6:0], 1'b0};
         end
         // Next byte follows the last group with no gap
         if (out_cnt_ff == (dual_ff ? sfr_pkg::DUAL_LAST : sfr_pkg::SINGLE_LAST)) begin
            nxt_out_cnt = sfr_pkg::OUT_ZERO;
         end else begin
            nxt_out_cnt = out_cnt_ff + sfr_pkg::OUT_ONE;
         end
      end
   end

   // Registers of the shifter; line values hold when released
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         out_cnt_ff <= sfr_pkg::OUT_ZERO;
         sh_ff      <= 8'h00;
         so_ff      <= '{oe: 1'b0, d: 1'b0};
         si_ff      <= '{oe: 1'b0, d: 1'b0};
      end else begin
         out_cnt_ff <= nxt_out_cnt;
         sh_ff      <= nxt_sh;
         so_ff      <= nxt_so;
         si_ff      <= nxt_si;
      end
   end

   assign so_o    = so_ff.d;
   assign so_oe_o = so_ff.oe;
   assign si_o    = si_ff.d;
   assign si_oe_o = si_ff.oe;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence addr_done_s;
      cs_act && sck_rise && (state_ff == sfr_pkg::ST_ADDR) && (bit_cnt_ff == sfr_pkg::ADDR_LAST);
   endsequence

   sequence dual_start_s;
      byte_start && dual_ff && cs_act;
   endsequence

   cmd_decode_a: assert property (cs_act && sck_rise && (state_ff == sfr_pkg::ST_CMD)
      && (bit_cnt_ff == sfr_pkg::CMD_LAST) && (cmd_full == sfr_pkg::OP_READ_DUAL)
      |=> (state_ff == sfr_pkg::ST_ADDR) && dual_ff)
      else $error("dual opcode not decoded");
   addr_load_a: assert property (addr_done_s |=> fetch_addr_ff == $past(addr_full))
      else $error("start address not loaded");
   dummy_skip_a: assert property (addr_done_s ##0 (cmd_ff == sfr_pkg::OP_READ_FAST)
      |=> (state_ff == sfr_pkg::ST_DUMMY) ##1 (state_ff == sfr_pkg::ST_DUMMY)[*2])
      else $error("fast read did not enter dummy phase");
   single_msb_a: assert property (byte_start && !dual_ff && cs_act |=> so_oe_o && (so_o == $past(head[7])))
      else $error("single byte MSB wrong");
   addr_step_a: assert property (issue && (fetch_addr_ff != sfr_pkg::ARRAY_LAST)
      |=> fetch_addr_ff == $past(fetch_addr_ff) + sfr_pkg::ADDR_STEP)
      else $error("read counter did not advance");
   so_float_a: assert property (!cs_act |=> !so_oe_o)
      else $error("SO driven without chip select");
   addr_wrap_a: assert property (issue && (fetch_addr_ff == sfr_pkg::ARRAY_LAST)
      |=> fetch_addr_ff == sfr_pkg::ARRAY_FIRST)
      else $error("read counter did not wrap");
   si_turn_a: assert property (dual_start_s |=> si_oe_o && so_oe_o)
      else $error("SI not turned to output");
   dual_group_a: assert property (sck_fall && dual_ff && (state_ff == sfr_pkg::ST_DATA)
      && (out_cnt_ff == sfr_pkg::DUAL_LAST) |=> out_cnt_ff == sfr_pkg::OUT_ZERO)
      else $error("dual byte not four clocks");
   dual_pair_a: assert property (dual_start_s |=> (so_o == $past(head[7])) && (si_o == $past(head[6])))
      else $error("dual bit pair misplaced");
   si_float_a: assert property (!cs_act |=> !si_oe_o)
      else $error("SI driven without chip select");
   fall_only_a: assert property ($changed(so_o) |-> $past(sck_fall))
      else $error("SO changed off a falling edge");

endmodule

/* sfr_pkg.sv */
// Constants and carrier types for the serial flash array read path
package sfr_pkg;

   // ==========================================================================
   // Opcodes of the array read commands
   localparam logic [7:0]  OP_READ_SLOW = 8'h03;
   localparam logic [7:0]  OP_READ_FAST = 8'h0B;
   localparam logic [7:0]  OP_READ_DUAL = 8'h3B;

   // ==========================================================================
   // Field lengths, as the last value of the serial clock counter
   localparam logic [5:0]  CMD_LAST     = 6'h07;
   localparam logic [5:0]  ADDR_LAST    = 6'h17;
   localparam logic [5:0]  DUMMY_LAST   = 6'h07;
   localparam logic [5:0]  CNT_ZERO     = 6'h00;
   localparam logic [5:0]  CNT_ONE      = 6'h01;

   // Data clocks per byte: eight on one line, four on two lines
   localparam logic [2:0]  SINGLE_LAST  = 3'h7;
   localparam logic [2:0]  DUAL_LAST    = 3'h3;
   localparam logic [2:0]  OUT_ZERO     = 3'h0;
   localparam logic [2:0]  OUT_ONE      = 3'h1;

   // ==========================================================================
   // Array bounds; the read counter wraps from last to first
   localparam logic [23:0] ARRAY_LAST   = 24'h03FFFF;
   localparam logic [23:0] ARRAY_FIRST  = 24'h000000;
   localparam logic [23:0] ADDR_STEP    = 24'h000001;

   // ==========================================================================
   // Two-entry byte buffer between array and shifter
   localparam logic [1:0]  BUF_DEPTH    = 2'h2;
   localparam logic [1:0]  BUF_EMPTY    = 2'h0;
   localparam logic [1:0]  BUF_ONE      = 2'h1;

   // ==========================================================================
   // Pin synchroniser: positions in the pin vector and idle levels
   localparam int          PIN_SI       = 0;
   localparam int          PIN_SCLK     = 1;
   localparam int          PIN_CS       = 2;
   localparam logic [2:0]  PIN_IDLE     = 3'h4;

   // ==========================================================================
   // Timing: system clock and slowest link clock the bench uses
   localparam int          MCLK_PERIOD_NS = 25;
   localparam int          SCLK_PERIOD_NS = 200;
   localparam int          SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2) / MCLK_PERIOD_NS;

   // ==========================================================================
   // Transfer phases, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_ADDR  = 3'b001,
      ST_DUMMY = 3'b011,
      ST_DATA  = 3'b010,
      ST_SKIP  = 3'b110
   } sfr_state_t;

   // Filtered serial pins
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } sfr_pins_t;

   // One data line: value and enable
   typedef struct packed {
      logic oe;
      logic d;
   } sfr_drive_t;

endpackage

/* sfr_host_model.sv */
// SPI host model: drives chip select, serial clock and SI, collects read bytes
`timescale 1ns/1ps
module sfr_host_model (
   // Pins towards the device
   output logic       cs_n_o,
   output logic       sclk_o,
   output logic       si_line_o,
   // Device line drivers
   input  wire logic  si_i,
   input  wire logic  si_oe_i,
   input  wire logic  so_i,
   input  wire logic  so_oe_i,
   // Received bytes and drive summary
   output logic [7:0] rx_byte_o,
   output logic       rx_stb_o,
   output logic [1:0] seen_oe_o
);
   // ==========================================================================
   // Line resolution
   logic h_oe;
   logic h_si;
   logic so_w;

   // A released line flips, so a stale level can never pass for data
   always @(si_oe_i, si_i, h_oe, h_si) begin
      if (si_oe_i)
         si_line_o = si_i;
      else if (h_oe)
         si_line_o = h_si;
      else
         si_line_o = ~si_line_o;
   end

   // SO has no pull either
   always @(so_oe_i, so_i) begin
      if (so_oe_i)
         so_w = so_i;
      else
         so_w = ~so_w;
   end

   // Idle: deselected, clock still
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      h_oe = 1'b0;
      h_si = 1'b0;
      si_line_o = 1'b0;
      so_w = 1'b0;
      rx_byte_o = 8'h00;
      rx_stb_o = 1'b0;
      seen_oe_o = 2'b00;
   end

   // ==========================================================================
   // One frame; nd data clocks, partial bytes are dropped
   task automatic frame(input logic [7:0] op, input logic [23:0] a, input int nd, input bit m3);
      logic [39:0] hdr;
      logic [7:0]  sh;
      int          nh;
      int          bpc;
      bit          known;
      known = (op == sfr_pkg::OP_READ_SLOW) || (op == sfr_pkg::OP_READ_FAST) || (op == sfr_pkg::OP_READ_DUAL);
      nh = (op == sfr_pkg::OP_READ_SLOW || !known) ? 32 : 40;
      bpc = (op == sfr_pkg::OP_READ_DUAL) ? 2 : 1;
      hdr = {op, a, 8'($urandom)};
      sh = 8'h00;
      seen_oe_o = 2'b00;
      sclk_o = m3;
      #(200 + $urandom_range(24, 0));
      cs_n_o = 1'b0;
      #100;
      // 200 ns period keeps every opcode under the low-frequency limit
      for (int i = 0; i < nh + nd; i++) begin
         sclk_o = 1'b0;
         h_oe = (i < nh);
         if (i < nh)
            h_si = hdr[39 - i];
         #100 sclk_o = 1'b1;
         #100 seen_oe_o = seen_oe_o | {si_oe_i, so_oe_i};
         if (i >= nh) begin
            sh = (bpc == 2) ? {sh[5:0], so_w, si_line_o} : {sh[6:0], so_w};
            if (known && ((i - nh + 1) % (8 / bpc) == 0)) begin
               rx_byte_o = sh;
               rx_stb_o = 1'b1;
               #1 rx_stb_o = 1'b0;
            end
         end
      end
      if (!m3) begin
         sclk_o = 1'b0;
         #100;
      end
      cs_n_o = 1'b1;
      h_oe = 1'b0;
   endtask
endmodule

/* serial_flash_array_read_bench.sv */
// Self-checking bench for the serial flash array read path
`timescale 1ns/1ps
module serial_flash_array_read_bench;
   // ==========================================================================
   // Signals
   logic        mclk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        cs_n, sclk, si_line, si_o, si_oe_o, so_o, so_oe_o;
   logic        mem_req_o, mem_rready_o, rx_stb;
   logic        mem_rvalid_i = 1'b0;
   logic        tk = 1'b0;
   logic        pend = 1'b0;
   logic [23:0] mem_addr_o;
   logic [23:0] pa = 24'h000000;
   logic [7:0]  mem_rdata_i = 8'h00;
   logic [7:0]  rx_byte, exp_b, op;
   logic [1:0]  seen_oe;
   logic [7:0]  exp_q[$];
   logic [7:0]  ops[3] = '{sfr_pkg::OP_READ_SLOW, sfr_pkg::OP_READ_FAST, sfr_pkg::OP_READ_DUAL};
   int          n_errors = 0;
   int          comparisons = 0;
   int          dly = 0;

   // 40 MHz system clock
   always #12.5 mclk_i = ~mclk_i;

   // ==========================================================================
   // Device and host
   sfr_read dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si_line),
      .si_o(si_o), .si_oe_o(si_oe_o), .so_o(so_o), .so_oe_o(so_oe_o), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
      .mem_rready_o(mem_rready_o));
   sfr_host_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .si_line_o(si_line), .si_i(si_o),
      .si_oe_i(si_oe_o), .so_i(so_o), .so_oe_i(so_oe_o), .rx_byte_o(rx_byte), .rx_stb_o(rx_stb),
      .seen_oe_o(seen_oe));

   // ==========================================================================
   // Array content; the top address byte matters so a missed wrap shows
   function automatic logic [7:0] arr_byte(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5C;
   endfunction

   // Handshake seen at the rising edge, released at the next falling one
   always @(posedge mclk_i) tk <= mem_rvalid_i & mem_rready_o;

   // Array model: one answer per request, stalling up to one cycle
   always @(negedge mclk_i) begin
      if (tk)
         mem_rvalid_i <= 1'b0;
      if (mem_req_o) begin
         pa = mem_addr_o;
         dly = int'($urandom_range(1, 0));
      end
      if (mem_req_o || pend) begin
         pend = (dly != 0);
         if (dly == 0) begin
            mem_rvalid_i <= 1'b1;
            mem_rdata_i <= arr_byte(pa);
         end
         dly = dly - 1;
      end
   end

   // ==========================================================================
   // Checking and closing
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test;
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Each received byte against the oldest note; a surplus byte always fails
   always @(posedge rx_stb) begin
      exp_b = (exp_q.size() > 0) ? exp_q.pop_front() : ~rx_byte;
      chk("rx_byte", {16'h0000, rx_byte}, {16'h0000, exp_b});
   end

   // One frame: note expected bytes, run it, then expect released lines
   task automatic run(input logic [7:0] opc, input logic [23:0] a, input int nb, input int extra, input bit m3);
      logic [23:0] ad;
      bit          dual;
      bit          known;
      int          k;
      ad = a;
      dual = (opc == sfr_pkg::OP_READ_DUAL);
      known = dual || (opc == sfr_pkg::OP_READ_SLOW) || (opc == sfr_pkg::OP_READ_FAST);
      for (int i = 0; i < nb; i++) begin
         exp_q.push_back(arr_byte(ad));
         ad = (ad == sfr_pkg::ARRAY_LAST) ? sfr_pkg::ARRAY_FIRST : ad + 24'h000001;
      end
      host_u.frame(opc, a, nb * (dual ? 4 : 8) + extra, m3);
      chk("seen_oe", {22'h00000, seen_oe}, {22'h00000, dual, known});
      k = 0;
      while ((so_oe_o || si_oe_o) && k < 20) begin
         @(negedge mclk_i);
         k++;
      end
      chk("oe_after_cs", {22'h00000, si_oe_o, so_oe_o}, 24'h000000);
      chk("bytes_left", 24'(exp_q.size()), 24'h000000);
      if (so_oe_o || si_oe_o)
         end_of_test();
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      void'($urandom(82));
      repeat (3) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      chk("idle", {20'h00000, si_oe_o, so_oe_o, mem_req_o, mem_rready_o}, 24'h000001);
      run(sfr_pkg::OP_READ_SLOW, 24'h012345, 3, 0, 1'b0);
      run(sfr_pkg::OP_READ_FAST, 24'h03FFFE, 4, 0, 1'b1);
      run(sfr_pkg::OP_READ_DUAL, 24'h03FFFF, 3, 0, 1'b0);
      run(sfr_pkg::OP_READ_DUAL, 24'h000100, 2, 3, 1'b1);
      run(sfr_pkg::OP_READ_SLOW, 24'h03FFFF, 2, 5, 1'b1);
      run(8'hC5, 24'h000000, 0, 16, 1'b0);
      // Random mix of opcodes, addresses, lengths, cut points and idle levels
      for (int i = 0; i < 8; i++) begin
         op = ops[$urandom_range(2, 0)];
         run(op, 24'($urandom_range(32'h0003FFFF, 0)), int'($urandom_range(4, 1)),
             int'($urandom_range(3, 0)), 1'($urandom));
      end
      end_of_test();
   end
endmodule
